// ==== src/usbefa_pkg.sv ====
// Package of the endpoint FIFO access block: register offsets, bit positions,
// reset values, endpoint sizes and the carrier structs.
// Assumes a byte-wide special-function-register bus and a serial engine on the USB side.

package usbefa_pkg;

    // ==========================================================================
    // Register offsets on the special-function-register bus
    // ==========================================================================
    localparam logic [7:0] USBEFA_LINE_ADDR   = 8'h2f;
    localparam logic [7:0] USBEFA_RXST_ADDR   = 8'he2;
    localparam logic [7:0] USBEFA_RXDATA_ADDR = 8'he3;
    localparam logic [7:0] USBEFA_RXCTL_ADDR  = 8'he4;
    localparam logic [7:0] USBEFA_RXLEN_ADDR  = 8'he6;
    localparam logic [7:0] USBEFA_EPSEL_ADDR  = 8'hf1;
    localparam logic [7:0] USBEFA_TXST_ADDR   = 8'hf2;
    localparam logic [7:0] USBEFA_TXDATA_ADDR = 8'hf3;
    localparam logic [7:0] USBEFA_TXCTL_ADDR  = 8'hf4;
    localparam logic [7:0] USBEFA_TXLEN_ADDR  = 8'hf6;

    // ==========================================================================
    // Field positions
    // ==========================================================================
    localparam int USBEFA_TOGGLE_BIT   = 7;
    localparam int USBEFA_SETUP_BIT    = 6;
    localparam int USBEFA_OWSTART_BIT  = 5;
    localparam int USBEFA_OWEND_BIT    = 4;
    localparam int USBEFA_OVERRIDE_BIT = 3;
    localparam int USBEFA_FLUSH_BIT    = 7;
    localparam int USBEFA_DONE_BIT     = 4;
    localparam int USBEFA_DPLUS_BIT    = 7;
    localparam int USBEFA_DMINUS_BIT   = 6;

    // ==========================================================================
    // Reset values, index codes and sizes
    // ==========================================================================
    localparam logic [7:0] USBEFA_BYTE_RST  = 8'h00;
    localparam logic [2:0] USBEFA_EPSEL_RST = 3'h0;
    localparam logic [2:0] USBEFA_EP_BUFFER = 3'h7;
    localparam int         USBEFA_NUM_EP    = 4;
    localparam int         USBEFA_CTRL_EP   = 0;
    localparam int         USBEFA_BUF_BYTES = 64;
    localparam int         USBEFA_EP_DEPTH [USBEFA_NUM_EP] = '{8, 8, 16, 32};

    // ==========================================================================
    // Carriers
    // ==========================================================================
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } usbefa_sfr_type;

    typedef struct packed {
        logic [1:0] ep;
        logic       setup_token;
        logic       setup_ok;
        logic       setup_hs;
        logic       out_ack;
        logic       in_ack;
        logic       rx_we;
        logic [7:0] rx_byte;
        logic       tx_re;
    } usbefa_sie_type;

endpackage

// ==== src/usbefa_fifo.sv ====
// Byte FIFO for one endpoint direction, with a one-cycle flush.
// Assumes writes and reads are single-cycle strobes in the clk_i domain.

`timescale 1ns/1ps
`default_nettype none

module usbefa_fifo #(
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Control
    input  wire logic       flush_i,
    // Write side
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    // Read side
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // Status
    output logic      [6:0] level_o,
    output logic            full_o,
    output logic            empty_o
);

    localparam int AW = $clog2(DEPTH);

    logic [7:0]  mem_q [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;

    wire logic do_wr = wr_i && !full_o && !flush_i;
    wire logic do_rd = rd_i && !empty_o && !flush_i;

    assign level_o = 7'(wp_q - rp_q);
    assign full_o  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty_o = (wp_q == rp_q);
    assign rdata_o = mem_q[rp_q[AW-1:0]];

    // Storage has no reset; only the pointers define what is valid.
    always_ff @(posedge clk_i)
    begin
        if (do_wr)
        begin
            mem_q[wp_q[AW-1:0]] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else if (flush_i)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            wp_q <= wp_q + (AW+1)'(do_wr);
            rp_q <= rp_q + (AW+1)'(do_rd);
        end
    end

endmodule

`default_nettype wire

// ==== src/usbefa_top.sv ====
// Endpoint FIFO access block: firmware register view of four endpoints plus a
// 64-byte buffer, and the byte/event port that faces the USB serial engine.
// Assumes the serial engine decodes tokens and handshakes and reports them as
// one-cycle strobes, and that the firmware bus is synchronous to clk_i.
//
// Behaviour
// - Valid SETUP received sets the setup-received flag of the endpoint the engine reports.
// - SETUP token on the control endpoint sets the read-only start-overwrite flag.
// - SETUP handshake sets end-overwrite; firmware clears it before reading data.
// - Receive override one lets the same write load the receive toggle; reads zero.
// - Receive toggle flips on each acknowledged OUT.
// - Receive data read returns next byte of the selected endpoint's FIFO.
// - Receive flush empties the FIFO, resets status, then self-clears.
// - Read-done releases the receive FIFO and self-clears when finished.
// - Receive count reports bytes of the held packet for endpoints 0-3.
// - With index seven, receive count is the buffer's low address byte.
// - Index 0-3 picks endpoints, 4-6 reserved, 7 selects the buffer.
// - Transmit toggle goes out in the data PID and flips on IN acknowledge.
// - Transmit override one lets the same write load the transmit toggle.
// - Transmit data write appends a byte to the selected endpoint's FIFO.
// - Transmit flush empties the FIFO, resets status, then self-clears.
// - Write-done commits the transmit FIFO for sending, then self-clears.
// - Transmit count holds the packet byte count for endpoints 0-3.
// - With index seven, transmit count is the buffer's high address byte.
// - Line-state register shows D+ and D- levels in bits seven and six.

`timescale 1ns/1ps
`default_nettype none

module usbefa_top
    import usbefa_pkg::*;
#(
    parameter int NUM_EP    = USBEFA_NUM_EP,
    parameter int BUF_BYTES = USBEFA_BUF_BYTES
) (
    // Clock and reset
    input  wire logic           clk_i,
    input  wire logic           sys_rst_i,
    // Firmware register bus
    input  wire usbefa_sfr_type sfr_i,
    output logic          [7:0] sfr_rdata_o,
    // Serial engine events and receive bytes
    input  wire usbefa_sie_type sie_i,
    // Bus line levels
    input  wire logic           dplus_level_i,
    input  wire logic           dminus_level_i,
    // Endpoint state towards the serial engine
    output logic   [NUM_EP-1:0] rx_data_toggle_o,
    output logic   [NUM_EP-1:0] tx_data_toggle_o,
    output logic   [NUM_EP-1:0] rx_full_o,
    output logic   [NUM_EP-1:0] tx_ready_o,
    // Transmit bytes towards the serial engine
    output logic          [7:0] tx_byte_o,
    output logic          [7:0] tx_count_o
);

    localparam int BAW = $clog2(BUF_BYTES);

    // ==========================================================================
    // State
    // ==========================================================================
    logic [2:0]        endpoint_select_q;
    logic [NUM_EP-1:0] rx_data_toggle_q;
    logic [NUM_EP-1:0] setup_received_q;
    logic [NUM_EP-1:0] setup_start_overwrite_q;
    logic [NUM_EP-1:0] setup_end_overwrite_q;
    logic [NUM_EP-1:0] tx_data_toggle_q;
    logic [NUM_EP-1:0] rx_fifo_flush_q;
    logic [NUM_EP-1:0] rx_read_done_q;
    logic [NUM_EP-1:0] tx_fifo_flush_q;
    logic [NUM_EP-1:0] tx_write_done_q;
    logic [NUM_EP-1:0] rx_full_q;
    logic [NUM_EP-1:0] tx_ready_q;
    logic [7:0]        rx_byte_count_q [NUM_EP];
    logic [7:0]        tx_byte_count_q [NUM_EP];
    logic [7:0]        buf_addr_lo_q;
    logic [7:0]        buf_addr_hi_q;
    logic [7:0]        buf_mem_q [BUF_BYTES];
    logic [7:0]        rdata_q;
    logic [7:0]        tx_byte_q;

    logic [7:0]        rx_head [NUM_EP];
    logic [7:0]        tx_head [NUM_EP];

    // ==========================================================================
    // Address decode
    // ==========================================================================
    wire logic       ep_valid  = !endpoint_select_q[2];
    wire logic       buf_mode  = (endpoint_select_q == USBEFA_EP_BUFFER);
    wire logic [1:0] ep_sel    = endpoint_select_q[1:0];
    wire logic [BAW-1:0] buf_addr = BAW'({buf_addr_hi_q, buf_addr_lo_q});

    wire logic hit_line   = (sfr_i.addr == USBEFA_LINE_ADDR);
    wire logic hit_epsel  = (sfr_i.addr == USBEFA_EPSEL_ADDR);
    wire logic hit_rxst   = (sfr_i.addr == USBEFA_RXST_ADDR);
    wire logic hit_rxdata = (sfr_i.addr == USBEFA_RXDATA_ADDR);
    wire logic hit_rxctl  = (sfr_i.addr == USBEFA_RXCTL_ADDR);
    wire logic hit_rxlen  = (sfr_i.addr == USBEFA_RXLEN_ADDR);
    wire logic hit_txst   = (sfr_i.addr == USBEFA_TXST_ADDR);
    wire logic hit_txdata = (sfr_i.addr == USBEFA_TXDATA_ADDR);
    wire logic hit_txctl  = (sfr_i.addr == USBEFA_TXCTL_ADDR);
    wire logic hit_txlen  = (sfr_i.addr == USBEFA_TXLEN_ADDR);

    wire logic wr_epsel  = sfr_i.wr && hit_epsel;
    wire logic wr_rxst   = sfr_i.wr && hit_rxst && ep_valid;
    wire logic wr_rxctl  = sfr_i.wr && hit_rxctl && ep_valid;
    wire logic wr_txst   = sfr_i.wr && hit_txst && ep_valid;
    wire logic wr_txdata = sfr_i.wr && hit_txdata && ep_valid;
    wire logic wr_txctl  = sfr_i.wr && hit_txctl && ep_valid;
    wire logic wr_txlen  = sfr_i.wr && hit_txlen && ep_valid;
    wire logic rd_rxdata = sfr_i.rd && hit_rxdata && ep_valid;
    wire logic wr_buf    = sfr_i.wr && hit_txdata && buf_mode;
    wire logic wr_buf_lo = sfr_i.wr && hit_rxlen && buf_mode;
    wire logic wr_buf_hi = sfr_i.wr && hit_txlen && buf_mode;

    // Reserved bit positions read as zero, so the written pattern only matters
    // at the named fields; anything else firmware puts there is dropped.
    wire logic wd_toggle   = sfr_i.wdata[USBEFA_TOGGLE_BIT];
    wire logic wd_setup    = sfr_i.wdata[USBEFA_SETUP_BIT];
    wire logic wd_owend    = sfr_i.wdata[USBEFA_OWEND_BIT];
    wire logic wd_override = sfr_i.wdata[USBEFA_OVERRIDE_BIT];
    wire logic wd_flush    = sfr_i.wdata[USBEFA_FLUSH_BIT];
    wire logic wd_done     = sfr_i.wdata[USBEFA_DONE_BIT];

    // ==========================================================================
    // Read data selection
    // ==========================================================================
    wire logic [7:0] line_val   = {dplus_level_i, dminus_level_i, 6'h00};
    wire logic [7:0] rxst_val   = {rx_data_toggle_q[ep_sel], setup_received_q[ep_sel],
                                   setup_start_overwrite_q[ep_sel],
                                   setup_end_overwrite_q[ep_sel], 4'h0};
    wire logic [7:0] txst_val   = {tx_data_toggle_q[ep_sel], 7'h00};
    wire logic [7:0] rxdata_val = buf_mode ? buf_mem_q[buf_addr] :
                                  ep_valid ? rx_head[ep_sel] : USBEFA_BYTE_RST;
    wire logic [7:0] rxlen_val  = buf_mode ? buf_addr_lo_q :
                                  ep_valid ? rx_byte_count_q[ep_sel] : USBEFA_BYTE_RST;

    wire logic [7:0] rd_val =
        hit_line              ? line_val :
        hit_epsel             ? {5'h00, endpoint_select_q} :
        hit_rxst && ep_valid  ? rxst_val :
        hit_rxdata            ? rxdata_val :
        hit_rxlen             ? rxlen_val :
        hit_txst && ep_valid  ? txst_val :
                                USBEFA_BYTE_RST;

    assign sfr_rdata_o      = rdata_q;
    assign rx_data_toggle_o = rx_data_toggle_q;
    assign tx_data_toggle_o = tx_data_toggle_q;
    assign rx_full_o        = rx_full_q;
    assign tx_ready_o       = tx_ready_q;
    assign tx_byte_o        = tx_byte_q;
    assign tx_count_o       = tx_byte_count_q[sie_i.ep];

    // ==========================================================================
    // Shared registers
    // ==========================================================================
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            endpoint_select_q <= USBEFA_EPSEL_RST;
            buf_addr_lo_q     <= USBEFA_BYTE_RST;
            buf_addr_hi_q     <= USBEFA_BYTE_RST;
            rdata_q           <= USBEFA_BYTE_RST;
            tx_byte_q         <= USBEFA_BYTE_RST;
        end
        else
        begin
            if (wr_epsel)
            begin
                endpoint_select_q <= sfr_i.wdata[2:0];
            end
            if (wr_buf_lo)
            begin
                buf_addr_lo_q <= sfr_i.wdata;
            end
            if (wr_buf_hi)
            begin
                buf_addr_hi_q <= sfr_i.wdata;
            end
            if (sfr_i.rd)
            begin
                rdata_q <= rd_val;
            end
            if (sie_i.tx_re)
            begin
                tx_byte_q <= tx_head[sie_i.ep];
            end
        end
    end

    // The buffer has no reset; firmware owns its contents entirely.
    always_ff @(posedge clk_i)
    begin
        if (wr_buf)
        begin
            buf_mem_q[buf_addr] <= sfr_i.wdata;
        end
    end

    // ==========================================================================
    // Per-endpoint state and FIFOs
    // ==========================================================================
    for (genvar g = 0; g < NUM_EP; g++)
    begin : g_ep
        wire logic hit   = (ep_sel == 2'(g));
        wire logic ev    = (sie_i.ep == 2'(g));
        wire logic ctrl  = (g == USBEFA_CTRL_EP);

        wire logic setup_set = ev && sie_i.setup_ok;
        wire logic setup_clr = wr_rxst && hit && !wd_setup;
        wire logic sow_set   = ctrl && ev && sie_i.setup_token;
        wire logic eow_set   = ctrl && ev && sie_i.setup_hs;
        wire logic eow_clr   = wr_rxst && hit && !wd_owend;
        wire logic rx_ovr    = wr_rxst && hit && wd_override;
        wire logic tx_ovr    = wr_txst && hit && wd_override;
        wire logic rx_rel    = rx_fifo_flush_q[g] || rx_read_done_q[g];
        wire logic rx_push   = ev && sie_i.rx_we;
        wire logic rx_pop    = rd_rxdata && hit;
        wire logic tx_push   = wr_txdata && hit;
        wire logic tx_pop    = ev && sie_i.tx_re;
        wire logic rx_full_set = ev && (sie_i.out_ack || sie_i.setup_hs);

        // A new SETUP overwrites whatever the control FIFO still held.
        wire logic rx_flush  = rx_rel || sow_set;

        usbefa_fifo #(
            .DEPTH (USBEFA_EP_DEPTH[g])
        ) u_rx_fifo (
            .clk_i     (clk_i),
            .sys_rst_i (sys_rst_i),
            .flush_i   (rx_flush),
            .wr_i      (rx_push),
            .wdata_i   (sie_i.rx_byte),
            .rd_i      (rx_pop),
            .rdata_o   (rx_head[g]),
            .level_o   (),
            .full_o    (),
            .empty_o   ()
        );

        usbefa_fifo #(
            .DEPTH (USBEFA_EP_DEPTH[g])
        ) u_tx_fifo (
            .clk_i     (clk_i),
            .sys_rst_i (sys_rst_i),
            .flush_i   (tx_fifo_flush_q[g]),
            .wr_i      (tx_push),
            .wdata_i   (sfr_i.wdata),
            .rd_i      (tx_pop),
            .rdata_o   (tx_head[g]),
            .level_o   (),
            .full_o    (),
            .empty_o   ()
        );

        always_ff @(posedge clk_i or posedge sys_rst_i)
        begin
            if (sys_rst_i)
            begin
                rx_data_toggle_q[g]        <= 1'b0;
                setup_received_q[g]        <= 1'b0;
                setup_start_overwrite_q[g] <= 1'b0;
                setup_end_overwrite_q[g]   <= 1'b0;
                tx_data_toggle_q[g]        <= 1'b0;
                rx_fifo_flush_q[g]         <= 1'b0;
                rx_read_done_q[g]          <= 1'b0;
                tx_fifo_flush_q[g]         <= 1'b0;
                tx_write_done_q[g]         <= 1'b0;
                rx_full_q[g]               <= 1'b0;
                tx_ready_q[g]              <= 1'b0;
                rx_byte_count_q[g]         <= USBEFA_BYTE_RST;
                tx_byte_count_q[g]         <= USBEFA_BYTE_RST;
            end
            else
            begin
                // Command bits last one cycle: the action runs while they are set.
                rx_fifo_flush_q[g] <= wr_rxctl && hit && wd_flush;
                rx_read_done_q[g]  <= wr_rxctl && hit && wd_done;
                tx_fifo_flush_q[g] <= wr_txctl && hit && wd_flush;
                tx_write_done_q[g] <= wr_txctl && hit && wd_done;

                // Hardware sets win over firmware clears in the same cycle.
                setup_received_q[g] <= setup_set || (setup_received_q[g] && !setup_clr);
                setup_start_overwrite_q[g] <= sow_set ||
                                              (setup_start_overwrite_q[g] && !rx_rel);
                setup_end_overwrite_q[g] <= eow_set ||
                    (setup_end_overwrite_q[g] && !eow_clr && !rx_fifo_flush_q[g]);
                rx_full_q[g] <= rx_full_set || (rx_full_q[g] && !rx_rel);

                if (rx_ovr)
                begin
                    rx_data_toggle_q[g] <= wd_toggle;
                end
                else if (ev && sie_i.out_ack)
                begin
                    rx_data_toggle_q[g] <= !rx_data_toggle_q[g];
                end

                if (tx_ovr)
                begin
                    tx_data_toggle_q[g] <= wd_toggle;
                end
                else if (ev && sie_i.in_ack)
                begin
                    tx_data_toggle_q[g] <= !tx_data_toggle_q[g];
                end

                if (rx_flush)
                begin
                    rx_byte_count_q[g] <= USBEFA_BYTE_RST;
                end
                else if (rx_push)
                begin
                    rx_byte_count_q[g] <= rx_byte_count_q[g] + 8'h01;
                end

                if (tx_fifo_flush_q[g])
                begin
                    tx_byte_count_q[g] <= USBEFA_BYTE_RST;
                end
                else if (wr_txlen && hit)
                begin
                    tx_byte_count_q[g] <= sfr_i.wdata;
                end

                // Committed data stays ready until the host acknowledges it or a transmit flush runs.
                // The FIFO is read out as it is sent, so a lost IN needs a refill.
                tx_ready_q[g] <= tx_write_done_q[g] ||
                    (tx_ready_q[g] && !(ev && sie_i.in_ack) && !tx_fifo_flush_q[g]);
            end
        end
    end

endmodule

`default_nettype wire

// ==== sim/usbefa_top_properties.sv ====
// Port checker for usbefa_top.
// Assumes it is bound into the design by the bench.
`timescale 1ns/1ps
`default_nettype none
module usbefa_top_properties
    import usbefa_pkg::*;
#(
    parameter int NUM_EP = 4
) (
    // Block inputs
    input wire logic              clk_i,
    input wire logic              sys_rst_i,
    input wire usbefa_sfr_type    sfr_i,
    input wire usbefa_sie_type    sie_i,
    input wire logic              dplus_level_i,
    input wire logic              dminus_level_i,
    // Block outputs
    input wire logic        [7:0] sfr_rdata_o,
    input wire logic [NUM_EP-1:0] rx_data_toggle_o,
    input wire logic [NUM_EP-1:0] tx_data_toggle_o,
    input wire logic [NUM_EP-1:0] rx_full_o,
    input wire logic [NUM_EP-1:0] tx_ready_o
);
    // ==========================================================================
    // Properties
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    wire rxs_wr = sfr_i.wr && sfr_i.addr == USBEFA_RXST_ADDR;
    wire txs_wr = sfr_i.wr && sfr_i.addr == USBEFA_TXST_ADDR;
    wire ctl_rd = sfr_i.rd && (sfr_i.addr == USBEFA_RXCTL_ADDR || sfr_i.addr == USBEFA_TXCTL_ADDR);
    // A commit landing on the same edge would win, so the write before is excluded.
    sequence s_in_ack1;
        sie_i.in_ack && sie_i.ep == 2'h1 && !$past(sfr_i.wr);
    endsequence
    a_rx_tog_flip: assert property (sie_i.out_ack && sie_i.ep == 2'h0 && !rxs_wr
        |=> rx_data_toggle_o[0] != $past(rx_data_toggle_o[0])) else $error("rx toggle no flip");
    a_rx_tog_quiet: assert property (!sie_i.out_ack && !sfr_i.wr |=> $stable(rx_data_toggle_o))
        else $error("rx toggle moved");
    a_tx_tog_flip: assert property (sie_i.in_ack && sie_i.ep == 2'h1 && !txs_wr
        |=> tx_data_toggle_o[1] != $past(tx_data_toggle_o[1])) else $error("tx toggle no flip");
    a_tx_tog_quiet: assert property (!sie_i.in_ack && !sfr_i.wr |=> $stable(tx_data_toggle_o))
        else $error("tx toggle moved");
    a_rdata_hold: assert property (!sfr_i.rd |=> $stable(sfr_rdata_o))
        else $error("read data moved");
    a_line_state: assert property (sfr_i.rd && sfr_i.addr == USBEFA_LINE_ADDR |=>
        sfr_rdata_o == {$past(dplus_level_i), $past(dminus_level_i), 6'h00}) else $error("line");
    a_ctrl_reads_zero: assert property (ctl_rd |=> sfr_rdata_o == 8'h00)
        else $error("control read not zero");
    a_rx_full_set: assert property (sie_i.out_ack && sie_i.ep == 2'h0 |=> rx_full_o[0])
        else $error("rx full not set");
    a_tx_ready_clr: assert property (s_in_ack1 |=> !tx_ready_o[1])
        else $error("tx ready kept");
endmodule
`default_nettype wire

// ==== sim/usbefa_host_model.sv ====
// Host-side serial engine model driving token, handshake and byte strobes.
// Assumes the caller lets one transfer finish before the next.
`timescale 1ns/1ps
`default_nettype none
module usbefa_host_model
    import usbefa_pkg::*;
(
    // Clock
    input  wire logic      clk_i,
    // Engine strobes
    output var usbefa_sie_type sie_o
);
    // ==========================================================================
    // Transfers
    initial sie_o = '0;
    // The byte lane shows the inverse after a push, so stale data never matches.
    task automatic send(input logic [1:0] ep, input logic [5:0] ev, input logic [7:0] b,
                        input logic pop);
        @(posedge clk_i);
        sie_o <= {ep, ev, b, pop};
        @(posedge clk_i);
        sie_o <= {ep, 6'h00, ~b, 1'b0};
    endtask
endmodule
`default_nettype wire

// ==== sim/usbefa_top_tb.sv ====
// Self-checking bench of usbefa_top with a host engine model.
// Assumes one-cycle register strobes and read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module usbefa_top_tb;
    import usbefa_pkg::*;
    logic           clk_i = 1'b0;
    logic           sys_rst_i = 1'b1;
    usbefa_sfr_type sfr = '0;
    usbefa_sie_type sie;
    logic [7:0]     rdata, tx_byte, tx_count;
    logic [3:0]     rx_tog, tx_tog, rx_full, tx_ready;
    logic           dplus = 1'b1;
    logic           dminus = 1'b0;
    int             n_errors = 0;
    int             cmp_count = 0;
    int             cycles = 0;
    always #25 clk_i = ~clk_i;
    usbefa_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
        .sie_i(sie), .dplus_level_i(dplus), .dminus_level_i(dminus), .rx_data_toggle_o(rx_tog),
        .tx_data_toggle_o(tx_tog), .rx_full_o(rx_full), .tx_ready_o(tx_ready),
        .tx_byte_o(tx_byte), .tx_count_o(tx_count));
    usbefa_host_model host (.clk_i(clk_i), .sie_o(sie));
    // ==========================================================================
    // Access and compare tasks
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk_i);
        sfr.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk_i);
        sfr.rd <= 1'b0;
        #1 chk8($sformatf("reg %h", a), exp, rdata);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            print_verdict;
        end
    end
    // ==========================================================================
    // Scenarios
    initial
    begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(USBEFA_LINE_ADDR, 8'h80);
        @(posedge clk_i);
        dplus <= 1'b0;
        dminus <= 1'b1;
        rd(USBEFA_LINE_ADDR, 8'h40);
        wr(USBEFA_EPSEL_ADDR, 8'h00);
        for (int i = 0; i < 3; i++) host.send(2'h0, 6'h20 >> i, 8'h00, 1'b0);
        rd(USBEFA_RXST_ADDR, 8'h70);
        wr(USBEFA_RXST_ADDR, 8'h00);
        rd(USBEFA_RXST_ADDR, 8'h20);
        wr(USBEFA_RXST_ADDR, 8'h88);
        rd(USBEFA_RXST_ADDR, 8'ha0);
        for (int i = 1; i < 4; i++) host.send(2'h0, 6'h01, 8'(8'h11 * i), 1'b0);
        host.send(2'h0, 6'h04, 8'h00, 1'b0);
        #1 chk1("rx full", 1'b1, rx_full[0]);
        chk1("rx toggle", 1'b0, rx_tog[0]);
        rd(USBEFA_RXST_ADDR, 8'h20);
        rd(USBEFA_RXLEN_ADDR, 8'h03);
        for (int i = 1; i < 4; i++) rd(USBEFA_RXDATA_ADDR, 8'(8'h11 * i));
        wr(USBEFA_RXCTL_ADDR, 8'h10);
        rd(USBEFA_RXLEN_ADDR, 8'h00);
        chk1("rx full", 1'b0, rx_full[0]);
        host.send(2'h0, 6'h01, 8'h5a, 1'b0);
        host.send(2'h0, 6'h04, 8'h00, 1'b0);
        #1 chk1("rx full", 1'b1, rx_full[0]);
        chk1("rx toggle", 1'b1, rx_tog[0]);
        wr(USBEFA_RXCTL_ADDR, 8'h80);
        rd(USBEFA_RXLEN_ADDR, 8'h00);
        chk1("rx full", 1'b0, rx_full[0]);
        rd(USBEFA_RXCTL_ADDR, 8'h00);
        wr(USBEFA_EPSEL_ADDR, 8'h01);
        wr(USBEFA_TXDATA_ADDR, 8'hc1);
        wr(USBEFA_TXDATA_ADDR, 8'hc2);
        wr(USBEFA_TXLEN_ADDR, 8'h02);
        wr(USBEFA_TXCTL_ADDR, 8'h10);
        host.send(2'h1, 6'h00, 8'h00, 1'b1);
        #1 chk1("tx ready", 1'b1, tx_ready[1]);
        chk8("tx count", 8'h02, tx_count);
        chk8("tx byte", 8'hc1, tx_byte);
        host.send(2'h1, 6'h02, 8'h00, 1'b0);
        rd(USBEFA_TXST_ADDR, 8'h80);
        chk1("tx ready", 1'b0, tx_ready[1]);
        chk1("tx toggle", 1'b1, tx_tog[1]);
        wr(USBEFA_TXST_ADDR, 8'h08);
        wr(USBEFA_TXST_ADDR, 8'h80);
        rd(USBEFA_TXST_ADDR, 8'h00);
        wr(USBEFA_EPSEL_ADDR, 8'h07);
        wr(USBEFA_RXLEN_ADDR, 8'h05);
        rd(USBEFA_RXLEN_ADDR, 8'h05);
        wr(USBEFA_TXLEN_ADDR, 8'h00);
        wr(USBEFA_TXDATA_ADDR, 8'ha5);
        rd(USBEFA_RXDATA_ADDR, 8'ha5);
        wr(USBEFA_EPSEL_ADDR, 8'h05);
        rd(USBEFA_RXLEN_ADDR, 8'h00);
        print_verdict;
    end
endmodule
bind usbefa_top usbefa_top_properties #(.NUM_EP(NUM_EP)) u_props (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .sfr_i(sfr_i), .sie_i(sie_i), .dplus_level_i(dplus_level_i),
    .dminus_level_i(dminus_level_i), .sfr_rdata_o(sfr_rdata_o), .rx_full_o(rx_full_o),
    .rx_data_toggle_o(rx_data_toggle_o), .tx_data_toggle_o(tx_data_toggle_o),
    .tx_ready_o(tx_ready_o));
`default_nettype wire
